// ---- design/flash_accel_pkg.sv ----
// Shared constants, types and word selection for the flash fetch accelerator.
package flash_accel_pkg;
    // Line, word and address widths, and the number of line buffers.
    localparam int LINE_W = 128;
    localparam int WORD_W = 32;
    localparam int LADDR_W = 15;
    localparam int ADDR_W = 19;
    localparam int NBUF = 3;
    // Field positions inside a byte address.
    localparam int LINE_LSB = 4;
    localparam int WSEL_LSB = 2;
    // Buffer indices.
    localparam int BUF_PF = 0;
    localparam int BUF_BT = 1;
    localparam int BUF_DATA = 2;
    // Operating mode codes.
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PART = 2'h1;
    localparam logic [1:0] MODE_FULL = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [1:0] MODE_RST = MODE_OFF;
    // Flash access length codes, in processor clocks.
    localparam logic [2:0] LEN_RSVD = 3'h0;
    localparam logic [2:0] LEN_ONE = 3'h1;
    localparam logic [2:0] LEN_RST = 3'h7;
    // Incrementer step from one line to the next.
    localparam logic [LADDR_W-1:0] LINE_STEP = 15'h0001;

    // Controller states.
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_MIMIC, ST_WAITPF} core_state_t;

    // Thirty-two 4:1 bit multiplexers pick one word out of a line.
    function automatic logic [WORD_W-1:0] word_of(input logic [LINE_W-1:0] line, input logic [1:0] sel);
        logic [WORD_W-1:0] w;
        w = '0;
        for (int b = 0; b < WORD_W; b++) begin
            w[b] = line[{sel, 5'(b)}];
        end
        return w;
    endfunction : word_of
endpackage : flash_accel_pkg

// ---- design/line_buffer.sv ----
// One line buffer with its line latch, address latch, comparator and word select.
module line_buffer (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Load and invalidate.
    input wire logic i_inv,
    input wire logic i_load,
    input wire logic [flash_accel_pkg::LADDR_W-1:0] i_load_addr,
    input wire logic [flash_accel_pkg::LINE_W-1:0] i_load_line,
    // Lookup.
    input wire logic [flash_accel_pkg::LADDR_W-1:0] i_req_addr,
    input wire logic [1:0] i_wsel,
    output logic o_valid,
    output logic o_hit,
    output logic [flash_accel_pkg::WORD_W-1:0] o_word
);
    import flash_accel_pkg::*;

    logic valid, next_valid; // Line holds good flash contents.
    logic [LADDR_W-1:0] tag, next_tag; // Line address latch.
    logic [LINE_W-1:0] line, next_line; // Four-word line latch.

    // Invalidate wins over a load so that stale flash data never survives.
    always_comb begin
        next_valid = valid;
        next_tag = tag;
        next_line = line;
        if (i_inv) begin
            next_valid = 1'b0;
        end else if (i_load) begin
            next_valid = 1'b1;
            next_tag = i_load_addr;
            next_line = i_load_line;
        end
    end

    // Register the buffer state.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            valid <= 1'b0;
            tag <= '0;
            line <= '0;
        end else begin
            valid <= next_valid;
            tag <= next_tag;
            line <= next_line;
        end
    end

    assign o_valid = valid;
    assign o_hit = valid && (tag == i_req_addr);
    assign o_word = word_of(line, i_wsel);
endmodule : line_buffer

// ---- design/flash_timer.sv ----
// Access length counter used for real flash reads and imitated ones.
module flash_timer (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Start and length.
    input wire logic i_start,
    input wire logic [2:0] i_len,
    output logic o_done
);
    import flash_accel_pkg::*;

    logic run, next_run; // An access is being timed.
    logic [2:0] cnt, next_cnt; // Clocks spent so far.

    // A start restarts the count, which is how an abort is carried out.
    always_comb begin
        next_run = run;
        next_cnt = cnt;
        if (i_start) begin
            next_run = 1'b1;
            next_cnt = LEN_ONE;
        end else if (run) begin
            if (cnt == i_len) begin
                next_run = 1'b0;
            end else begin
                next_cnt = cnt + LEN_ONE;
            end
        end
    end

    // Register the counter.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            run <= 1'b0;
            cnt <= LEN_RSVD;
        end else begin
            run <= next_run;
            cnt <= next_cnt;
        end
    end

    assign o_done = run && (cnt == i_len);
endmodule : flash_timer

// ---- design/flash_fetch_accelerator.sv ----
// Flash read accelerator with prefetch, branch trail and data line buffers.
// How it works
// - Three separate 128-bit line buffers.
// - Full miss stalls core for whole line read.
// - Pending prefetch hit waits only for it.
// - Prefetch starts once flash finishes previous access.
// - Prefetched line held; taken on match, else dropped.
// - Line holds four words or eight halfwords.
// - Instruction and data use separate buffers.
// - Data line miss reads flash, aborts prefetch.
// - Aborted prefetch restarts after data read.
// - Branch target line goes to branch buffer.
// - Prefetch address from latch plus incrementer.
// - Each buffer has 15-bit tag and comparator.
// - Word chosen by thirty-two 4:1 muxes.
// - Data miss loads four-word line into buffer.
// - Flash busy holds requests in idle; demand and imitated reads still strobe.
// - Program or erase start invalidates all buffers.
// - Mode 0: flash timing always, no prefetch.
// - Mode 1: sequential hits buffered, prefetch on.
// - Mode 2: all hits buffered, prefetch on.
// - Forced fetch on hit imitates flash timing.
// - DMA reads behave like core data reads.
// - Length of one clock adds no stall.
// - Mode codes off, partial, full; 11 reserved.
// - Access length 1 to 7; resets to 7.
// - Mode change invalidates all three buffers.
// - Starts disabled after reset.
module flash_fetch_accelerator (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Core and DMA fetch bus.
    input wire logic i_req,
    input wire logic i_instr,
    input wire logic i_dma,
    input wire logic [flash_accel_pkg::ADDR_W-1:0] i_addr,
    output logic o_core_wait_strobe,
    output logic [flash_accel_pkg::WORD_W-1:0] o_rdata,
    // Configuration.
    input wire logic i_mode_wr,
    input wire logic [1:0] i_accel_operating_mode_field,
    input wire logic i_length_wr,
    input wire logic [2:0] i_flash_access_length_field,
    output logic [1:0] o_mode,
    output logic [2:0] o_length,
    // Flash bank.
    input wire logic i_flash_busy,
    input wire logic [flash_accel_pkg::LINE_W-1:0] i_flash_line,
    output logic o_flash_rd,
    output logic [flash_accel_pkg::LADDR_W-1:0] o_flash_line_addr
);
    import flash_accel_pkg::*;

    // Controller state.
    core_state_t st, next_st;
    logic [1:0] mode, next_mode; // Operating mode.
    logic [2:0] cycles, next_cycles; // Flash access length in clocks.
    logic [LADDR_W-1:0] last_line, next_last_line; // Previous instruction line.
    logic last_valid, next_last_valid;
    logic req_seq, next_req_seq; // Demand instruction read was sequential.
    logic req_data, next_req_data; // Demand read serves the data buffer.
    logic ready, next_ready; // Wait strobe pulse.
    logic [WORD_W-1:0] rdata, next_rdata;
    // Flash access state.
    logic fl_rd, next_fl_rd;
    logic fl_pf, next_fl_pf; // Current read is a prefetch.
    logic [LADDR_W-1:0] fl_addr, next_fl_addr; // Flash address latch.
    // Prefetched line held at the flash output.
    logic hold_valid, next_hold_valid;
    logic [LADDR_W-1:0] hold_addr, next_hold_addr;
    logic [LINE_W-1:0] hold_line, next_hold_line;
    logic busy_q; // Flash busy one clock ago, for the start edge.

    // Lookup and steering signals.
    logic [LADDR_W-1:0] req_line;
    logic [1:0] wsel;
    logic [NBUF-1:0] hit, valid, ld;
    logic [WORD_W-1:0] bword [NBUF];
    logic [LADDR_W-1:0] ld_addr, pf_line;
    logic [LINE_W-1:0] ld_line;
    logic is_data, seq, use_buf, hold_hit, pend_hit, ibuf_hit, inv;
    logic t_done, fl_done, fl_start, mim_start, mim_done;
    logic [WORD_W-1:0] ibuf_word;

    assign req_line = i_addr[ADDR_W-1:LINE_LSB];
    assign wsel = i_addr[LINE_LSB-1:WSEL_LSB];
    assign is_data = !i_instr || i_dma;
    assign seq = last_valid && (req_line == last_line || req_line == last_line + LINE_STEP);
    assign use_buf = (mode == MODE_FULL) || (mode == MODE_PART && seq);
    assign hold_hit = hold_valid && (hold_addr == req_line);
    assign pend_hit = fl_rd && fl_pf && (fl_addr == req_line);
    assign ibuf_hit = hit[BUF_PF] || hit[BUF_BT];
    assign ibuf_word = hit[BUF_PF] ? bword[BUF_PF] : hit[BUF_BT] ? bword[BUF_BT] : word_of(hold_line, wsel);
    assign inv = (i_mode_wr && i_accel_operating_mode_field != MODE_RSVD && i_accel_operating_mode_field != mode)
        || (i_flash_busy && !busy_q);
    assign fl_done = t_done && fl_rd;

    // Three line buffers, each with its own tag, comparator and word select.
    generate
        for (genvar g = 0; g < NBUF; g++) begin : g_buf
            line_buffer u_buf (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_inv(inv),
                .i_load(ld[g]),
                .i_load_addr(ld_addr),
                .i_load_line(ld_line),
                .i_req_addr(req_line),
                .i_wsel(wsel),
                .o_valid(valid[g]),
                .o_hit(hit[g]),
                .o_word(bword[g])
            );
        end
    endgenerate

    // Times real flash reads; a restart aborts whatever was running.
    flash_timer u_flash_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(fl_start),
        .i_len(cycles),
        .o_done(t_done)
    );

    // Times imitated reads so a forced fetch costs what a real one does.
    flash_timer u_mimic_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(mim_start),
        .i_len(cycles),
        .o_done(mim_done)
    );

    // Next state of the whole controller.
    always_comb begin
        next_st = st;
        next_mode = mode;
        next_cycles = cycles;
        next_last_line = last_line;
        next_last_valid = last_valid;
        next_req_seq = req_seq;
        next_req_data = req_data;
        next_ready = 1'b0;
        next_rdata = rdata;
        next_fl_rd = fl_rd;
        next_fl_pf = fl_pf;
        next_fl_addr = fl_addr;
        next_hold_valid = hold_valid;
        next_hold_addr = hold_addr;
        next_hold_line = hold_line;
        ld = '0;
        ld_addr = req_line;
        ld_line = i_flash_line;
        fl_start = 1'b0;
        mim_start = 1'b0;
        // Reserved codes are ignored so the field keeps a legal value.
        if (i_mode_wr && i_accel_operating_mode_field != MODE_RSVD) begin
            next_mode = i_accel_operating_mode_field;
        end
        if (i_length_wr && i_flash_access_length_field != LEN_RSVD) begin
            next_cycles = i_flash_access_length_field;
        end
        // A finished prefetch stays at the flash output until an instruction request claims or drops it, or an invalidate clears it.
        if (fl_done) begin
            next_fl_rd = 1'b0;
            if (fl_pf) begin
                next_hold_valid = 1'b1;
                next_hold_addr = fl_addr;
                next_hold_line = i_flash_line;
            end
        end
        unique case (st)
            ST_IDLE: begin
                // Busy flash keeps the request waiting here.
                if (i_req && !i_flash_busy) begin
                    next_rdata = bword[BUF_DATA];
                    if (!is_data) begin
                        next_last_line = req_line;
                        next_last_valid = 1'b1;
                        next_req_seq = seq;
                        next_req_data = 1'b0;
                        // The held line is either claimed now or dropped.
                        next_hold_valid = 1'b0;
                        next_rdata = ibuf_word;
                        if (use_buf && ibuf_hit) begin
                            next_ready = 1'b1;
                        end else if (use_buf && hold_hit) begin
                            ld[BUF_PF] = 1'b1;
                            ld_line = hold_line;
                            next_ready = 1'b1;
                        end else if (use_buf && pend_hit) begin
                            if (fl_done) begin
                                ld[BUF_PF] = 1'b1;
                                next_rdata = word_of(i_flash_line, wsel);
                                next_ready = 1'b1;
                            end else begin
                                next_st = ST_WAITPF;
                            end
                        end else if (ibuf_hit || hold_hit) begin
                            // Buffered word, but the mode wants flash timing.
                            if (cycles == LEN_ONE) begin
                                next_ready = 1'b1;
                            end else begin
                                mim_start = 1'b1;
                                next_st = ST_MIMIC;
                            end
                        end else begin
                            fl_start = 1'b1;
                        end
                    end else begin
                        next_req_data = 1'b1;
                        if (hit[BUF_DATA] && mode == MODE_FULL) begin
                            next_ready = 1'b1;
                        end else if (hit[BUF_DATA] && cycles == LEN_ONE) begin
                            next_ready = 1'b1;
                        end else if (hit[BUF_DATA]) begin
                            mim_start = 1'b1;
                            next_st = ST_MIMIC;
                        end else begin
                            fl_start = 1'b1;
                        end
                    end
                    // A demand read takes the bank and aborts any prefetch.
                    if (fl_start) begin
                        next_fl_rd = 1'b1;
                        next_fl_pf = 1'b0;
                        next_fl_addr = req_line;
                        next_st = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // The whole line lands in the buffer of its kind.
                if (fl_done) begin
                    ld_addr = fl_addr;
                    ld[BUF_DATA] = req_data;
                    ld[BUF_PF] = !req_data && req_seq;
                    ld[BUF_BT] = !req_data && !req_seq;
                    next_rdata = word_of(i_flash_line, wsel);
                    next_ready = 1'b1;
                    next_st = ST_IDLE;
                end
            end
            ST_MIMIC: begin
                if (mim_done) begin
                    next_ready = 1'b1;
                    next_st = ST_IDLE;
                end
            end
            ST_WAITPF: begin
                // A killed prefetch sends the request back for a fresh look.
                if (fl_done) begin
                    ld_addr = fl_addr;
                    ld[BUF_PF] = 1'b1;
                    next_hold_valid = 1'b0;
                    next_rdata = word_of(i_flash_line, wsel);
                    next_ready = 1'b1;
                    next_st = ST_IDLE;
                end else if (!fl_rd) begin
                    next_st = ST_IDLE;
                end
            end
        endcase
        // Program, erase or mode change drops held data and any prefetch.
        if (inv) begin
            next_hold_valid = 1'b0;
            if (fl_pf) begin
                next_fl_rd = 1'b0;
            end
        end
        // Prefetch the next line whenever the bank is free, outside mode 0, unless that line is already held.
        pf_line = next_last_line + LINE_STEP;
        if (!next_fl_rd && !inv && !i_flash_busy && next_mode != MODE_OFF && next_last_valid
            && !(next_hold_valid && next_hold_addr == pf_line)) begin
            fl_start = 1'b1;
            next_fl_rd = 1'b1;
            next_fl_pf = 1'b1;
            next_fl_addr = pf_line;
        end
    end

    // Register the controller.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st <= ST_IDLE;
            mode <= MODE_RST;
            cycles <= LEN_RST;
            last_line <= '0;
            last_valid <= 1'b0;
            req_seq <= 1'b0;
            req_data <= 1'b0;
            ready <= 1'b0;
            rdata <= '0;
            fl_rd <= 1'b0;
            fl_pf <= 1'b0;
            fl_addr <= '0;
            hold_valid <= 1'b0;
            hold_addr <= '0;
            hold_line <= '0;
            busy_q <= 1'b0;
        end else begin
            st <= next_st;
            mode <= next_mode;
            cycles <= next_cycles;
            last_line <= next_last_line;
            last_valid <= next_last_valid;
            req_seq <= next_req_seq;
            req_data <= next_req_data;
            ready <= next_ready;
            rdata <= next_rdata;
            fl_rd <= next_fl_rd;
            fl_pf <= next_fl_pf;
            fl_addr <= next_fl_addr;
            hold_valid <= next_hold_valid;
            hold_addr <= next_hold_addr;
            hold_line <= next_hold_line;
            busy_q <= i_flash_busy;
        end
    end

    assign o_core_wait_strobe = ready;
    assign o_rdata = rdata;
    assign o_mode = mode;
    assign o_length = cycles;
    assign o_flash_rd = fl_rd;
    assign o_flash_line_addr = fl_addr;

    // Helper age of the running flash read, only read by the checks.
    logic [2:0] rd_age;
    always_ff @(posedge i_core_clk) begin
        if (i_rst || fl_start) begin
            rd_age <= LEN_ONE;
        end else begin
            rd_age <= rd_age + LEN_ONE;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // A data read that misses, then completes.
    sequence s_data_miss;
        st == ST_IDLE && i_req && !i_flash_busy && is_data && !hit[BUF_DATA];
    endsequence
    sequence s_read_done;
        st == ST_READ && fl_done;
    endsequence

    busy_stall_a: assert property ((st == ST_IDLE && i_req && i_flash_busy) |=> !ready)
        else $error("wait strobe given while flash busy");
    reset_mode_a: assert property ($past(i_rst) |-> mode == MODE_OFF && cycles == LEN_RST)
        else $error("mode or length wrong after reset");
    read_length_a: assert property (fl_done |-> rd_age == cycles)
        else $error("flash read length differs from setting");
    miss_reply_a: assert property (s_read_done |=> ready && st == ST_IDLE)
        else $error("no wait strobe after flash read");
    off_nopf_a: assert property (mode == MODE_OFF && !inv |-> !(fl_start && next_fl_pf))
        else $error("prefetch issued in mode 0");
    prog_inval_a: assert property ($rose(i_flash_busy) |=> valid == '0 && !hold_valid)
        else $error("buffers survive program start");
    mode_inval_a: assert property ((next_mode != mode) |=> valid == '0)
        else $error("buffers survive mode change");
    data_abort_a: assert property (s_data_miss |=> fl_rd && !fl_pf && st == ST_READ)
        else $error("data miss did not take the flash");
    pf_restart_a: assert property ((s_read_done ##0 req_data && mode != MODE_OFF && !i_flash_busy
        && !inv && !hold_valid && last_valid) |=> fl_rd && fl_pf)
        else $error("prefetch not restarted after data read");
    data_hit_a: assert property ((st == ST_IDLE && i_req && !i_flash_busy && is_data && mode == MODE_FULL
        && hit[BUF_DATA]) |=> ready && (fl_pf || !fl_rd))
        else $error("data hit not served at once");
endmodule : flash_fetch_accelerator

// ---- tb/flash_bank_model.sv ----
// Behavioural flash bank that answers the line address it is given.
module flash_bank_model (
    // Clock and read port.
    input wire logic i_core_clk,
    input wire logic i_rd,
    input wire logic [14:0] i_line_addr,
    output logic [127:0] o_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] junk = 32'h0000_0000; // Idle pattern that changes every cycle.
    // The idle pattern moves so that a stale line can never pass for a good one.
    always @(posedge i_core_clk) begin
        junk <= junk + 32'h0000_0001;
    end
    // Word k of a line is its address, a marker and k.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_line[k*32+:32] = i_rd ? {i_line_addr, 15'h5a5a, 2'(k)} : junk ^ 32'(k);
        end
    end
endmodule : flash_bank_model

// ---- tb/flash_fetch_accelerator_test.sv ----
// Self-checking bench for the flash fetch accelerator.
module flash_fetch_accelerator_test import flash_accel_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 0, i_rst = 1, i_req = 0, i_instr = 0, i_dma = 0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic i_mode_wr = 0, i_length_wr = 0, i_flash_busy = 0;
    logic [1:0] i_accel_operating_mode_field = '0;
    logic [2:0] i_flash_access_length_field = '0;
    logic o_core_wait_strobe, o_flash_rd;
    logic [WORD_W-1:0] o_rdata;
    logic [1:0] o_mode;
    logic [2:0] o_length;
    logic [LINE_W-1:0] i_flash_line;
    logic [LADDR_W-1:0] o_flash_line_addr;
    logic [WORD_W-1:0] notes[$]; // Expected words, oldest first.
    int fails = 0, cmp_count = 0, cycles = 0, len = 7;

    flash_fetch_accelerator flash_fetch_accelerator_inst (.i_core_clk, .i_rst, .i_req, .i_instr, .i_dma,
        .i_addr, .o_core_wait_strobe, .o_rdata, .i_mode_wr, .i_accel_operating_mode_field, .i_length_wr,
        .i_flash_access_length_field, .o_mode, .o_length, .i_flash_busy, .i_flash_line, .o_flash_rd,
        .o_flash_line_addr);
    flash_bank_model flash_bank_model_inst (.i_core_clk, .i_rd(o_flash_rd), .i_line_addr(o_flash_line_addr),
        .o_line(i_flash_line));

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Drops the request and lets n cycles pass.
    task automatic idle(input int n);
        i_req = 0;
        repeat (n) begin
            @(posedge i_core_clk);
            #2;
        end
    endtask : idle

    // Writes mode and length together; buffers are invalidated by a mode change.
    task automatic cfg(input logic [1:0] m, input logic [2:0] l);
        {i_mode_wr, i_accel_operating_mode_field, i_length_wr, i_flash_access_length_field} = {1'b1, m, 1'b1, l};
        idle(1);
        {i_mode_wr, i_length_wr} = 2'b00;
        if (l != 3'h0) len = l;
        idle(2);
    endtask : cfg

    // Keeps the request up until the strobe; elat 0 only bounds the wait by a full read.
    task automatic fetch(input logic ins, input logic dma, input logic [18:0] a, input int elat);
        int lat = 0;
        notes.push_back({a[18:4], 15'h5a5a, a[3:2]});
        {i_req, i_instr, i_dma, i_addr} = {1'b1, ins, dma, a};
        do begin
            @(posedge i_core_clk);
            #2;
            lat++;
        end while (o_core_wait_strobe !== 1'b1 && lat < 60);
        if (elat > 0) check(32'(lat), 32'(elat), "latency");
        else check(32'(lat <= len + 1), 32'h0000_0001, "latency bound");
    endtask : fetch

    // Waits a few cycles for the flash to read the given line.
    task automatic see_read(input logic [14:0] ln);
        int n = 0;
        i_req = 0;
        while (!(o_flash_rd === 1'b1 && o_flash_line_addr === ln) && n < 6) begin
            @(posedge i_core_clk);
            #2;
            n++;
        end
        check(32'(n < 6), 32'h0000_0001, "flash line read");
    endtask : see_read

    // Every answer takes the oldest note; a hang counts as a mismatch.
    always @(negedge i_core_clk) begin
        cycles++;
        if (cycles > 5000) begin
            fails++;
            print_verdict();
        end
        if (o_core_wait_strobe === 1'b1) check(o_rdata, notes.size() ? notes.pop_front() : 'x, "word");
    end

    initial begin
        logic [18:0] a;
        a = 19'($urandom(32'hb282));
        repeat (4) @(posedge i_core_clk);
        #2;
        check(32'(o_mode), 32'(MODE_OFF), "mode at reset");
        check(32'(o_length), 32'(LEN_RST), "length at reset");
        i_rst = 0;
        $display("test reset done");
        fetch(0, 0, 19'h0_0100, 8);
        fetch(0, 0, 19'h0_0104, 8);
        fetch(1, 0, 19'h0_0200, 8);
        idle(6);
        check(32'(o_flash_rd), 32'h0000_0000, "no prefetch");
        cfg(MODE_RSVD, LEN_RSVD);
        check(32'(o_mode), 32'(MODE_OFF), "reserved mode");
        check(32'(o_length), 32'(LEN_RST), "reserved length");
        $display("test mode 0 done");
        cfg(MODE_FULL, 3'h3);
        check(32'(o_mode), 32'(MODE_FULL), "mode");
        fetch(0, 0, 19'h0_0300, 4);
        fetch(0, 0, 19'h0_030c, 1);
        fetch(1, 1, 19'h0_0308, 1);
        fetch(1, 0, 19'h0_0304, 4);
        fetch(1, 0, 19'h0_0308, 1);
        fetch(0, 0, 19'h0_0300, 1);
        idle(8);
        fetch(1, 0, 19'h0_0310, 1);
        see_read(15'h0032);
        fetch(1, 0, 19'h0_0314, 1);
        fetch(1, 0, 19'h0_0320, 2);
        fetch(1, 0, 19'h0_0300, 1);
        fetch(0, 0, 19'h0_0400, 4);
        see_read(15'h0031);
        $display("test mode 2 done");
        cfg(MODE_PART, 3'h3);
        fetch(1, 0, 19'h0_0300, 4);
        fetch(1, 0, 19'h0_0304, 1);
        fetch(1, 0, 19'h0_0310, 2);
        fetch(1, 0, 19'h0_0300, 4);
        fetch(0, 0, 19'h0_0400, 4);
        fetch(0, 0, 19'h0_0404, 4);
        $display("test mode 1 done");
        cfg(MODE_OFF, LEN_ONE);
        fetch(0, 0, 19'h0_0600, 2);
        fetch(0, 0, 19'h0_0604, 1);
        $display("test length 1 done");
        cfg(MODE_FULL, 3'h3);
        fetch(0, 0, 19'h0_0700, 4);
        i_flash_busy = 1;
        idle(1);
        {i_req, i_instr, i_dma, i_addr} = {1'b1, 1'b0, 1'b0, 19'h0_0704};
        repeat (5) begin
            @(posedge i_core_clk);
            #2;
            check(32'(o_core_wait_strobe), 32'h0000_0000, "held off");
        end
        i_flash_busy = 0;
        fetch(0, 0, 19'h0_0704, 4);
        $display("test busy done");
        // Random word addresses; only the bound and the data are predictable here.
        repeat (6) begin
            a = 19'($urandom) & 19'h7_fffc;
            fetch(0, 0, a, 0);
        end
        idle(3);
        $display("test random done");
        print_verdict();
    end
endmodule : flash_fetch_accelerator_test
